// ==== rtl/timer8_waveform_modes.sv ====
// 8-bit timer core: normal, clear-on-match, fast PWM, phase-correct PWM.
// Assumes all control inputs come from logic on core_clk.
//
// Contract
// RULE1: Clear-on-match mode clears the counter on compare match.
// RULE2: Clear-on-match compare writes act at once; a passed value waits for wrap.
// RULE3: Clear-on-match toggle action inverts the output on every match.
// RULE4: Clear-on-match overflow flag sets when counter rolls from max to zero.
// RULE5: Clear-on-match raises the compare flag each time top is reached.
// RULE6: Fast PWM counts zero to max and wraps, 256 timer clocks.
// RULE7: Fast PWM action 2 clears on match, sets at bottom; 3 opposite.
// RULE8: Fast PWM sets the overflow flag whenever the counter reaches max.
// RULE9: Fast PWM compare zero gives spike; compare max gives constant level.
// RULE10: Fast PWM toggle action gives a square wave, compare still buffered.
// RULE11: Phase-correct PWM counts up then down, 510 timer clocks.
// RULE12: Phase-correct turns at max, holding max one timer clock.
// RULE13: Phase-correct action 2 clears on up match, sets on down; 3 inverted.
// RULE14: Phase-correct sets the overflow flag when counter reaches zero.
// RULE15: Phase-correct compare zero holds low, max holds high; inverted opposite.
// RULE16: Leaving compare max, output takes up-count result at turnaround.
// RULE17: A missed up-count match still applies its result at turnaround.
// RULE18: The pin is driven only when its direction selects output.
// RULE19: Timer clock divides input clock by 1, 8, 32, 64, 128, 256, 1024.
// RULE20: Action 0 leaves the output alone and the pin under port control.
// RULE21: PWM compare writes are buffered; other modes write the comparator.
// RULE22: Compare flag sets on the timer clock after counter equals compare.
// RULE23: Counter, output and flags change only on timer clock enables; counter writes, forced matches and flag clears act on any core_clk cycle.
`default_nettype none
module timer8_waveform_modes (
    input  wire logic                        core_clk,
    input  wire logic                        sys_rst,
    input  wire timer8_pkg::wave_mode_t      modeSelect,
    input  wire timer8_pkg::out_action_t     actionSelect,
    input  wire timer8_pkg::clk_sel_t        clockSelect,
    input  wire logic                        compareWrite,
    input  wire logic [7:0]                  compareWData,
    input  wire logic                        counterWrite,
    input  wire logic [7:0]                  counterWData,
    input  wire logic                        forceCompare,
    input  wire logic                        overflowClear,
    input  wire logic                        compareClear,
    input  wire logic                        pinDirOut,
    input  wire logic                        portValue,
    output var  logic [7:0]                  counterValue,
    output var  logic [7:0]                  compareValue,
    output var  logic [7:0]                  compareBuffer,
    output var  logic                        countingDown,
    output var  logic                        waveState,
    output var  logic                        overflowFlag,
    output var  logic                        compareMatchFlag,
    output var  logic                        pinOut,
    output var  logic                        pinOe
);
    logic       timerTick;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       dirUp_q;
    logic       dirUp_d;
    logic [7:0] ocr_q;
    logic [7:0] ocr_d;
    logic [7:0] ocrBuf_q;
    logic [7:0] ocrBuf_d;
    logic       blk_q;
    logic       blk_d;
    logic       oc_q;
    logic       oc_d;
    logic       pinOut_d;
    logic       pinOe_d;
    logic       ovfSet;
    logic       cmpSet;
    logic       match;
    logic       atMax;
    logic       atBottom;
    logic       isPwm;
    logic       upPhase;
    logic       upResult;
    logic       downResult;
    logic       actOn;

    timer8_prescaler #(
        .DIV_W (timer8_pkg::PRESC_W)
    ) u_prescaler (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .clockSelect (clockSelect),
        .timerTick   (timerTick)
    );

    // A counter write removes the match of the next timer clock
    assign match    = (cnt_q == ocr_q) && !blk_q;
    assign atMax    = (cnt_q == timer8_pkg::CNT_MAX);
    assign atBottom = (cnt_q == timer8_pkg::CNT_BOTTOM);
    assign isPwm    = (modeSelect == timer8_pkg::MODE_PHASE)
                   || (modeSelect == timer8_pkg::MODE_FAST);
    // Bottom counts as up-slope so compare zero always applies the up-count result
    assign upPhase    = dirUp_q || atBottom;
    assign upResult   = (actionSelect == timer8_pkg::ACT_SET);
    assign downResult = (actionSelect == timer8_pkg::ACT_CLEAR);
    assign actOn      = actionSelect[1];

    // Counter, direction and compare registers
    always_comb begin
        cnt_d    = cnt_q;
        dirUp_d  = dirUp_q;
        ocr_d    = ocr_q;
        blk_d    = blk_q;
        ovfSet   = 1'b0;
        cmpSet   = 1'b0;
        ocrBuf_d = compareWrite ? compareWData : ocrBuf_q;
        if (!isPwm && compareWrite) begin
            ocr_d = compareWData; // RULE2 RULE21
        end
        if (timerTick) begin // RULE23
            blk_d  = 1'b0;
            cmpSet = match; // RULE22 RULE5
            case (modeSelect)
                timer8_pkg::MODE_MATCH_CLEAR: begin
                    if (match) begin
                        cnt_d = timer8_pkg::CNT_BOTTOM; // RULE1
                    end else begin
                        cnt_d = cnt_q + 8'h01; // RULE2
                    end
                    ovfSet = atMax; // RULE4
                end
                timer8_pkg::MODE_FAST: begin
                    cnt_d  = cnt_q + 8'h01; // RULE6
                    ovfSet = atMax; // RULE8
                    if (atMax) begin
                        ocr_d = ocrBuf_d; // RULE21 RULE10
                    end
                end
                timer8_pkg::MODE_PHASE: begin
                    if (dirUp_q) begin
                        if (atMax) begin
                            dirUp_d = 1'b0; // RULE12
                            cnt_d   = timer8_pkg::CNT_MAX - 8'h01;
                            ocr_d   = ocrBuf_d; // RULE21
                        end else begin
                            cnt_d = cnt_q + 8'h01; // RULE11
                        end
                    end else begin
                        if (atBottom) begin
                            dirUp_d = 1'b1;
                            cnt_d   = cnt_q + 8'h01;
                        end else begin
                            cnt_d = cnt_q - 8'h01; // RULE11
                        end
                    end
                    ovfSet = !dirUp_q && (cnt_q == 8'h01); // RULE14
                end
                default: begin
                    cnt_d  = cnt_q + 8'h01;
                    ovfSet = atMax;
                end
            endcase
        end
        if (counterWrite) begin
            cnt_d = counterWData;
            blk_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_q    <= timer8_pkg::CNT_RST;
            dirUp_q  <= 1'b1;
            ocr_q    <= timer8_pkg::OCR_RST;
            ocrBuf_q <= timer8_pkg::OCR_RST;
            blk_q    <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            dirUp_q  <= dirUp_d;
            ocr_q    <= ocr_d;
            ocrBuf_q <= ocrBuf_d;
            blk_q    <= blk_d;
        end
    end

    // Waveform state and pin drive
    always_comb begin
        oc_d = oc_q;
        if (timerTick) begin // RULE23
            case (modeSelect)
                timer8_pkg::MODE_FAST: begin
                    if (actionSelect == timer8_pkg::ACT_TOGGLE) begin
                        if (match) begin
                            oc_d = !oc_q; // RULE10
                        end
                    end else if (actOn) begin
                        // Bottom wins, so compare max gives a steady level
                        if (atMax) begin
                            oc_d = downResult; // RULE7 RULE9
                        end else if (match) begin
                            oc_d = upResult; // RULE7 RULE9
                        end
                    end
                end
                timer8_pkg::MODE_PHASE: begin
                    if (actOn) begin
                        if (dirUp_q && atMax) begin
                            if (ocr_d == timer8_pkg::CNT_MAX) begin
                                oc_d = downResult; // RULE15
                            end else begin
                                oc_d = upResult; // RULE16 RULE17
                            end
                        end else if (match) begin
                            oc_d = upPhase ? upResult : downResult; // RULE13 RULE15
                        end
                    end
                end
                default: begin
                    if (match) begin
                        case (actionSelect)
                            timer8_pkg::ACT_TOGGLE: oc_d = !oc_q; // RULE3
                            timer8_pkg::ACT_CLEAR:  oc_d = 1'b0;
                            timer8_pkg::ACT_SET:    oc_d = 1'b1;
                            default:                oc_d = oc_q; // RULE20
                        endcase
                    end
                end
            endcase
        end
        // Forced match: output only, no flag and no counter clear
        if (forceCompare && !isPwm) begin
            case (actionSelect)
                timer8_pkg::ACT_TOGGLE: oc_d = !oc_q;
                timer8_pkg::ACT_CLEAR:  oc_d = 1'b0;
                timer8_pkg::ACT_SET:    oc_d = 1'b1;
                default:                oc_d = oc_q;
            endcase
        end
        pinOe_d = pinDirOut; // RULE18
        if (actionSelect == timer8_pkg::ACT_NONE) begin
            pinOut_d = portValue; // RULE20
        end else begin
            pinOut_d = oc_d; // RULE18
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            oc_q   <= timer8_pkg::WAVE_RST;
            pinOut <= 1'b0;
            pinOe  <= 1'b0;
        end else begin
            oc_q   <= oc_d;
            pinOut <= pinOut_d;
            pinOe  <= pinOe_d;
        end
    end

    timer8_sticky_flag u_overflow (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .flagSet   (ovfSet),
        .flagClear (overflowClear),
        .flag      (overflowFlag)
    );

    timer8_sticky_flag u_compare (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .flagSet   (cmpSet),
        .flagClear (compareClear),
        .flag      (compareMatchFlag)
    );

    assign counterValue  = cnt_q;
    assign compareValue  = ocr_q;
    assign compareBuffer = ocrBuf_q;
    assign countingDown  = !dirUp_q;
    assign waveState     = oc_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    chk_match_clear: assert property ( // RULE1
        modeSelect == timer8_pkg::MODE_MATCH_CLEAR && timerTick && match && !counterWrite
        |=> cnt_q == timer8_pkg::CNT_BOTTOM)
        else $error("Counter not cleared on match in clear-on-match mode");

    chk_match_toggle: assert property ( // RULE3
        modeSelect == timer8_pkg::MODE_MATCH_CLEAR && actionSelect == timer8_pkg::ACT_TOGGLE
        && timerTick && match && !forceCompare
        |=> oc_q != $past(oc_q))
        else $error("Output did not toggle on match");

    chk_ovf_wrap: assert property ( // RULE4
        modeSelect != timer8_pkg::MODE_PHASE && timerTick && atMax
        |=> overflowFlag)
        else $error("Overflow flag missing at wrap");

    chk_fast_bottom: assert property ( // RULE7
        modeSelect == timer8_pkg::MODE_FAST && actionSelect == timer8_pkg::ACT_CLEAR
        && timerTick && atMax && !forceCompare && !counterWrite
        |=> oc_q && cnt_q == timer8_pkg::CNT_BOTTOM)
        else $error("Fast PWM output not set at bottom");

    chk_phase_turn: assert property ( // RULE12
        modeSelect == timer8_pkg::MODE_PHASE && timerTick && dirUp_q && atMax
        && !counterWrite
        |=> cnt_q == timer8_pkg::CNT_MAX - 8'h01 && !dirUp_q)
        else $error("Phase-correct turnaround wrong");

    chk_phase_ovf: assert property ( // RULE14
        modeSelect == timer8_pkg::MODE_PHASE && timerTick && !dirUp_q
        && cnt_q == 8'h01 && !counterWrite
        |=> cnt_q == timer8_pkg::CNT_BOTTOM && overflowFlag)
        else $error("Overflow flag missing at bottom");

    chk_pin_release: assert property ( // RULE18
        !pinDirOut |=> !pinOe)
        else $error("Pin driven while direction is input");

    chk_cmp_flag: assert property ( // RULE22
        timerTick && match |=> compareMatchFlag)
        else $error("Compare flag not set after match");

    chk_tick_hold: assert property ( // RULE23
        !timerTick && !counterWrite && !forceCompare
        |=> $stable(cnt_q) && $stable(oc_q))
        else $error("State changed without timer clock");

    chk_port_pass: assert property ( // RULE20
        actionSelect == timer8_pkg::ACT_NONE |=> pinOut == $past(portValue))
        else $error("Pin not under port control");

    cov_fast_wrap: cover property (
        modeSelect == timer8_pkg::MODE_FAST && timerTick && atMax);
    cov_phase_turn: cover property (
        modeSelect == timer8_pkg::MODE_PHASE && timerTick && dirUp_q && atMax);
    cov_clear_match: cover property (
        modeSelect == timer8_pkg::MODE_MATCH_CLEAR && timerTick && match);
    // Leaving compare max: output flips at the top without a match
    cov_phase_leave_max: cover property (
        modeSelect == timer8_pkg::MODE_PHASE && timerTick && dirUp_q && atMax
        && ocr_q == timer8_pkg::CNT_MAX && ocr_d != timer8_pkg::CNT_MAX);
    cov_clear_race: cover property (
        ovfSet && overflowClear);
endmodule : timer8_waveform_modes
`default_nettype wire

// ==== rtl/timer8_pkg.sv ====
// Constants, codes and reset values of the 8-bit waveform timer.
// Assumes nothing; shared by the timer core and its helpers.
`default_nettype none
package timer8_pkg;
    localparam int unsigned CNT_W      = 8;
    localparam int unsigned PRESC_W    = 10;
    localparam logic [7:0]  CNT_MAX    = 8'hFF;
    localparam logic [7:0]  CNT_BOTTOM = 8'h00;
    localparam logic [7:0]  CNT_RST    = 8'h00;
    localparam logic [7:0]  OCR_RST    = 8'h00;
    localparam logic        WAVE_RST   = 1'b0;
    // Timer clocks per PWM period
    localparam int unsigned FAST_PERIOD  = 256;
    localparam int unsigned PHASE_PERIOD = 510;

    typedef enum logic [1:0] {
        MODE_NORMAL      = 2'b00,
        MODE_PHASE       = 2'b01,
        MODE_MATCH_CLEAR = 2'b10,
        MODE_FAST        = 2'b11
    } wave_mode_t;

    typedef enum logic [1:0] {
        ACT_NONE   = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLEAR  = 2'b10,
        ACT_SET    = 2'b11
    } out_action_t;

    typedef enum logic [2:0] {
        CS_STOP  = 3'b000,
        CS_DIV1  = 3'b001,
        CS_DIV8  = 3'b010,
        CS_DIV32 = 3'b011,
        CS_DIV64 = 3'b100,
        CS_DIV128 = 3'b101,
        CS_DIV256 = 3'b110,
        CS_DIV1024 = 3'b111
    } clk_sel_t;

    // Low-bit masks of the free-running divider per factor
    localparam logic [9:0] MASK_DIV1    = 10'h000;
    localparam logic [9:0] MASK_DIV8    = 10'h007;
    localparam logic [9:0] MASK_DIV32   = 10'h01F;
    localparam logic [9:0] MASK_DIV64   = 10'h03F;
    localparam logic [9:0] MASK_DIV128  = 10'h07F;
    localparam logic [9:0] MASK_DIV256  = 10'h0FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
endpackage : timer8_pkg
`default_nettype wire

// ==== rtl/timer8_prescaler.sv ====
// Divider making the one-cycle timer clock enable from core_clk.
// Assumes clockSelect comes from logic on core_clk.
`default_nettype none
module timer8_prescaler #(
    parameter int unsigned DIV_W = timer8_pkg::PRESC_W
) (
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    input  wire timer8_pkg::clk_sel_t     clockSelect,
    output var  logic                     timerTick
);
    if (DIV_W < timer8_pkg::PRESC_W) begin : g_width_check
        $error("Divider too narrow for factor 1024");
    end

    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic [9:0]       mask;
    logic             tick_d;

    always_comb begin
        div_d = div_q + 1'b1;
        case (clockSelect)
            timer8_pkg::CS_DIV1:   mask = timer8_pkg::MASK_DIV1;
            timer8_pkg::CS_DIV8:   mask = timer8_pkg::MASK_DIV8;
            timer8_pkg::CS_DIV32:  mask = timer8_pkg::MASK_DIV32;
            timer8_pkg::CS_DIV64:  mask = timer8_pkg::MASK_DIV64;
            timer8_pkg::CS_DIV128: mask = timer8_pkg::MASK_DIV128;
            timer8_pkg::CS_DIV256: mask = timer8_pkg::MASK_DIV256;
            default:               mask = timer8_pkg::MASK_DIV1024;
        endcase
        tick_d = (clockSelect != timer8_pkg::CS_STOP)
               && ((div_q[9:0] & mask) == mask); // RULE19
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            div_q     <= '0;
            timerTick <= 1'b0;
        end else begin
            div_q     <= div_d;
            timerTick <= tick_d;
        end
    end
endmodule : timer8_prescaler
`default_nettype wire

// ==== rtl/timer8_sticky_flag.sv ====
// One sticky status flag: hardware sets, the owner clears.
// Assumes set and clear come from logic on core_clk.
`default_nettype none
module timer8_sticky_flag (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic flagSet,
    input  wire logic flagClear,
    output var  logic flag
);
    logic flag_d;

    // Set beats a clear in the same cycle so no event is lost
    always_comb begin
        flag_d = flag;
        if (flagClear) begin
            flag_d = 1'b0;
        end
        if (flagSet) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else begin
            flag <= flag_d;
        end
    end
endmodule : timer8_sticky_flag
`default_nettype wire

// ==== verif/pin_load_model.sv ====
// Load on the waveform pin: a pull-down resistor behind the port driver.
// Assumes pinOut and pinOe come straight from the timer core.
`default_nettype none
module pin_load_model (
    input  wire logic pinOut,
    input  wire logic pinOe,
    output wire logic pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pin falls to the pull-down, it never keeps the last level
    assign pinLevel = pinOe ? pinOut : 1'b0;
endmodule : pin_load_model
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench of the 8-bit waveform timer with its pin load.
// Assumes the timer package, core and pin load model are compiled first.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [1:0] m;
        logic [1:0] a;
        logic [7:0] c;
        int         p;
        int         hi;
        int         ov;
        int         cm;
    } row_t;
    // Mode, action, compare, window, high cycles, overflow and match flag cycles
    row_t rows [13] = '{
        '{2'h1, 2'h2, 8'h40, 510, 128, 1, 2}, '{2'h1, 2'h3, 8'h40, 510, 382, 1, 2},
        '{2'h1, 2'h2, 8'h00, 510, 0, 1, 1},   '{2'h1, 2'h2, 8'hFF, 510, 510, 1, 1},
        '{2'h1, 2'h3, 8'h00, 510, 510, 1, 1}, '{2'h3, 2'h2, 8'h40, 256, 65, 1, 1},
        '{2'h3, 2'h3, 8'h40, 256, 191, 1, 1}, '{2'h3, 2'h2, 8'h00, 256, 1, 1, 1},
        '{2'h3, 2'h2, 8'hFF, 256, 256, 1, 1}, '{2'h3, 2'h3, 8'hFF, 256, 0, 1, 1},
        '{2'h3, 2'h1, 8'h10, 512, 256, 2, 2}, '{2'h2, 2'h1, 8'h00, 2, 1, 0, 2},
        '{2'h2, 2'h1, 8'h04, 10, 5, 0, 2}};
    int                      divs [8] = '{1, 8, 32, 64, 128, 256, 1024, 0};
    logic [2:0]              css  [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
    logic                    core_clk = 1'b0;
    logic                    sys_rst = 1'b1;
    timer8_pkg::wave_mode_t  modeSelect = timer8_pkg::MODE_NORMAL;
    timer8_pkg::out_action_t actionSelect = timer8_pkg::ACT_NONE;
    timer8_pkg::clk_sel_t    clockSelect = timer8_pkg::CS_DIV1;
    logic                    compareWrite = 1'b0;
    logic [7:0]              compareWData = 8'h00;
    logic                    counterWrite = 1'b0;
    logic [7:0]              counterWData = 8'h00;
    logic                    overflowClear = 1'b0;
    logic                    compareClear = 1'b0;
    logic                    forceCompare = 1'b0;
    logic                    pinDirOut = 1'b1;
    logic                    portValue = 1'b0;
    logic                    autoClr = 1'b1;
    logic [7:0]              counterValue, compareValue, compareBuffer, prev;
    logic                    countingDown, waveState, overflowFlag, compareMatchFlag;
    logic                    pinOut, pinOe, pinLevel;
    int                      n_errors = 0;
    int                      comparisons = 0;
    int                      hi, ov, cm, w;

    timer8_waveform_modes timer8_waveform_modes_i (
        .core_clk(core_clk), .sys_rst(sys_rst), .modeSelect(modeSelect),
        .actionSelect(actionSelect), .clockSelect(clockSelect),
        .compareWrite(compareWrite), .compareWData(compareWData),
        .counterWrite(counterWrite), .counterWData(counterWData), .forceCompare(forceCompare),
        .overflowClear(overflowClear), .compareClear(compareClear),
        .pinDirOut(pinDirOut), .portValue(portValue), .counterValue(counterValue),
        .compareValue(compareValue), .compareBuffer(compareBuffer),
        .countingDown(countingDown), .waveState(waveState), .overflowFlag(overflowFlag),
        .compareMatchFlag(compareMatchFlag), .pinOut(pinOut), .pinOe(pinOe));

    pin_load_model pin_load_model_i (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));

    always #5 core_clk = ~core_clk;

    // Clearing each flag right after it rises makes every event one cycle wide
    always @(negedge core_clk) begin
        overflowClear <= autoClr & overflowFlag;
        compareClear <= autoClr & compareMatchFlag;
    end

    task automatic print_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_cnt(input logic [7:0] v);
        int i;
        i = 0;
        while (counterValue !== v) begin
            @(negedge core_clk);
            i++;
            if (i > 2000) begin
                n_errors++;
                print_verdict();
            end
        end
    endtask : wait_cnt

    task automatic wr_cmp(input logic [7:0] v);
        compareWData = v;
        compareWrite = 1'b1;
        @(negedge core_clk);
        compareWrite = 1'b0;
    endtask : wr_cmp

    initial begin
        repeat (3) @(negedge core_clk);
        sys_rst = 1'b0;
        foreach (rows[k]) begin
            modeSelect = timer8_pkg::wave_mode_t'(rows[k].m);
            actionSelect = timer8_pkg::out_action_t'(rows[k].a);
            wr_cmp(rows[k].c);
            repeat (1100) @(negedge core_clk);
            hi = 0;
            ov = 0;
            cm = 0;
            repeat (rows[k].p) begin
                @(negedge core_clk);
                if (pinLevel === 1'b1) hi++;
                if (overflowFlag === 1'b1) ov++;
                if (compareMatchFlag === 1'b1) cm++;
            end
            check(16'(hi), 16'(rows[k].hi));
            check(16'(ov), 16'(rows[k].ov));
            check(16'(cm), 16'(rows[k].cm));
        end
        sys_rst = 1'b1;
        repeat (3) @(negedge core_clk);
        check({counterValue, compareValue}, 16'h0000);
        check({3'h0, compareBuffer, countingDown, waveState, overflowFlag,
               compareMatchFlag, pinOe}, 16'h0000);
        sys_rst = 1'b0;
        modeSelect = timer8_pkg::MODE_MATCH_CLEAR;
        actionSelect = timer8_pkg::ACT_TOGGLE;
        wr_cmp(8'hF0);
        wait_cnt(8'hA0);
        autoClr = 1'b0;
        wr_cmp(8'h10);
        check({8'h00, compareValue}, 16'h0010);
        wait_cnt(8'hFF);
        check({15'h0000, overflowFlag}, 16'h0000);
        @(negedge core_clk);
        check({counterValue, 7'h00, overflowFlag}, 16'h0001);
        check({15'h0000, compareMatchFlag}, 16'h0000);
        wait_cnt(8'h10);
        @(negedge core_clk);
        check({counterValue, 7'h00, compareMatchFlag}, 16'h0001);
        autoClr = 1'b1;
        modeSelect = timer8_pkg::MODE_FAST;
        wait_cnt(8'h20);
        wr_cmp(8'h33);
        check({compareValue, compareBuffer}, 16'h1033);
        wait_cnt(8'h00);
        check({8'h00, compareValue}, 16'h0033);
        modeSelect = timer8_pkg::MODE_NORMAL;
        for (int j = 0; j < 8; j++) begin
            clockSelect = timer8_pkg::clk_sel_t'(css[j]);
            repeat (70) @(negedge core_clk);
            w = (divs[j] == 0) ? 64 : 4 * divs[j];
            hi = 0;
            prev = counterValue;
            repeat (w) begin
                @(negedge core_clk);
                if (counterValue !== prev) hi++;
                prev = counterValue;
            end
            check(16'(hi), (divs[j] == 0) ? 16'h0000 : 16'h0004);
        end
        clockSelect = timer8_pkg::CS_DIV1;
        modeSelect = timer8_pkg::MODE_PHASE;
        actionSelect = timer8_pkg::ACT_CLEAR;
        wr_cmp(8'hFF);
        repeat (1100) @(negedge core_clk);
        wait_cnt(8'h10);
        if (countingDown === 1'b1) begin
            @(negedge core_clk);
            wait_cnt(8'h10);
        end
        check({15'h0000, pinLevel}, 16'h0001);
        // Written on the up-slope, so the next top loads it
        wr_cmp(8'h40);
        wait_cnt(8'hFE);
        repeat (2) @(negedge core_clk);
        check({counterValue, 7'h00, pinLevel}, 16'hFE00);
        wait_cnt(8'h10);
        if (countingDown === 1'b1) begin
            @(negedge core_clk);
            wait_cnt(8'h10);
        end
        check({15'h0000, pinLevel}, 16'h0001);
        // Jumping above the compare value skips the up-slope match
        counterWData = 8'h80;
        counterWrite = 1'b1;
        @(negedge core_clk);
        counterWrite = 1'b0;
        wait_cnt(8'hFE);
        @(negedge core_clk);
        check({8'h00, counterValue}, 16'h00FF);
        @(negedge core_clk);
        check({counterValue, 7'h00, pinLevel}, 16'hFE00);
        wait_cnt(8'h3F);
        check({15'h0000, pinLevel}, 16'h0001);
        pinDirOut = 1'b0;
        repeat (2) @(negedge core_clk);
        check({13'h0000, pinOe, pinLevel, waveState}, 16'h0001);
        actionSelect = timer8_pkg::ACT_NONE;
        portValue = 1'b1;
        pinDirOut = 1'b1;
        repeat (2) @(negedge core_clk);
        check({14'h0000, pinOe, pinLevel}, 16'h0003);
        // Stopped timer: only the forced match can move the output
        clockSelect = timer8_pkg::CS_STOP;
        modeSelect = timer8_pkg::MODE_NORMAL;
        actionSelect = timer8_pkg::ACT_CLEAR;
        forceCompare = 1'b1;
        @(negedge core_clk);
        forceCompare = 1'b0;
        repeat (2) @(negedge core_clk);
        check({13'h0000, waveState, pinLevel, compareMatchFlag}, 16'h0000);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
